// ### trig_regs.svh
// Offsets, field values and timing counts for the trigger and exposure block
`ifndef TRIG_REGS_SVH
`define TRIG_REGS_SVH

// Register indices (byte address is four times the index)
`define REG_MODE 4'h0
`define REG_EXPOSURE 4'h1
`define REG_TIMING 4'h2
`define REG_ROUTING 4'h3
`define REG_SOFT_TRIG 4'h4
`define REG_STATUS 4'h5

// Mode setting values
`define MODE_FREERUN 8'h00
`define MODE_BOARD 8'h10
`define MODE_PASS 8'ha0

// Exposure value limit and the board trigger pulse width
`define EXPOSURE_MAX 15'h639c
`define CLK_MHZ 200
`define US_CYCLES (`CLK_MHZ)
`define MS_CYCLES (1000 * `CLK_MHZ)
`define TRIG_PULSE_US 1
`define TRIG_PULSE_CYCLES (`TRIG_PULSE_US * `CLK_MHZ)

`endif

// ### trig_pkg.sv
// Types shared by the trigger and exposure block
package trig_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PULSE = 2'b01,
    ST_EXPOSURE_LINE = 2'b10
  } gen_state_type;
  typedef logic [14:0] exposure_type;
endpackage

// ### trig_input_sync.sv
// Three-stage synchroniser with rising-edge pulse for one external trigger pin
`timescale 1ns/10ps
`default_nettype none
module trig_input_sync (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // Pin and result
  input wire logic pin_i,
  output logic rise_o
);
  logic [2:0] sync_q;
  logic [2:0] sync_d;
  logic level_q;
  logic level_d;
  logic rise_q;
  logic rise_d;

  // Level accepted once stages two and three agree; stage one feeds only stage two
  always_comb begin
    sync_d = {sync_q[1:0], pin_i};
    level_d = level_q;
    if (sync_q[2] == sync_q[1]) begin
      level_d = sync_q[2];
    end
    rise_d = level_d & ~level_q;
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      sync_q <= 3'h0;
      level_q <= 1'b0;
      rise_q <= 1'b0;
    end else begin
      sync_q <= sync_d;
      level_q <= level_d;
      rise_q <= rise_d;
    end
  end

  assign rise_o = rise_q;
endmodule
`default_nettype wire

// ### trig_channel.sv
// Per-camera trigger generator: board pulse, timed exposure, or pass-through
`timescale 1ns/10ps
`default_nettype none
`include "trig_regs.svh"
module trig_channel
  import trig_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // Control
  input wire logic [7:0] trigger_mode_setting_i,
  input wire logic pulse_width_i,
  input wire logic shutter_timing_microsec_i,
  input wire trig_pkg::exposure_type exposure_i,
  input wire logic soft_trig_i,
  input wire logic ext_rise_i,
  // Camera line
  output logic exposure_line_o,
  output logic busy_o
);
  import trig_pkg::*;

  gen_state_type state_q;
  gen_state_type state_d;
  logic [31:0] unit_q;
  logic [31:0] unit_d;
  logic [14:0] left_q;
  logic [14:0] left_d;
  logic line_q;
  logic line_d;
  logic [31:0] unit_len;

  // One time unit in cycles, microsecond or millisecond
  always_comb begin
    unit_len = shutter_timing_microsec_i ? 32'(`US_CYCLES) : 32'(`MS_CYCLES);
  end

  // Trigger sequencing; new triggers while busy are ignored
  always_comb begin
    state_d = state_q;
    unit_d = unit_q;
    left_d = left_q;
    line_d = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (trigger_mode_setting_i == `MODE_BOARD && soft_trig_i) begin
          if (pulse_width_i) begin
            if (exposure_i != 15'h0) begin
              state_d = ST_EXPOSURE_LINE;
              left_d = exposure_i;
              unit_d = unit_len - 32'h1;
              line_d = 1'b1;
            end
          end else begin
            state_d = ST_PULSE;
            unit_d = 32'(`TRIG_PULSE_CYCLES) - 32'h1;
            line_d = 1'b1;
          end
        end else if (trigger_mode_setting_i == `MODE_PASS && ext_rise_i) begin
          state_d = ST_PULSE;
          unit_d = 32'(`TRIG_PULSE_CYCLES) - 32'h1;
          line_d = 1'b1;
        end
      end
      ST_PULSE: begin
        if (unit_q == 32'h0) begin
          state_d = ST_IDLE;
        end else begin
          unit_d = unit_q - 32'h1;
          line_d = 1'b1;
        end
      end
      ST_EXPOSURE_LINE: begin
        // High for exactly value times unit cycles
        if (unit_q != 32'h0) begin
          unit_d = unit_q - 32'h1;
          line_d = 1'b1;
        end else if (left_q != 15'h1) begin
          left_d = left_q - 15'h1;
          unit_d = unit_len - 32'h1;
          line_d = 1'b1;
        end else begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    // Freerun and external-direct: never drive a trigger
    if (trigger_mode_setting_i == `MODE_FREERUN) begin
      state_d = ST_IDLE;
      line_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      state_q <= ST_IDLE;
      unit_q <= 32'h0;
      left_q <= 15'h0;
      line_q <= 1'b0;
    end else begin
      state_q <= state_d;
      unit_q <= unit_d;
      left_q <= left_d;
      line_q <= line_d;
    end
  end

  assign exposure_line_o = line_q;
  assign busy_o = (state_q != ST_IDLE);
endmodule
`default_nettype wire

// ### trig_control.sv
// Operation
// - Mode 00: device drives no trigger
// - Mode 10: device generates camera trigger pulse
// - Pulse-width: line high exactly programmed duration
// - Millisecond timing: value 0-25500 in ms
// - Microsecond timing: same value in us
// - Mode A0: forward external trigger to camera
// - Routing: input 0 to both, or separate
// - External direct: configure freerun, drive nothing
`timescale 1ns/10ps
`default_nettype none
`include "trig_regs.svh"
module trig_control
  import trig_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [31:0] reg_rdata_o,
  // External trigger pins
  input wire logic [1:0] ext_trig_i,
  // Camera trigger lines
  output logic [1:0] exposure_line_o
);
  import trig_pkg::*;

  logic [7:0] mode_q;
  logic [7:0] mode_d;
  exposure_type exp_q;
  exposure_type exp_d;
  logic pw_q;
  logic pw_d;
  logic us_q;
  logic us_d;
  logic route_q;
  logic route_d;
  logic [1:0] soft_q;
  logic [1:0] soft_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [1:0] line_q;
  logic [1:0] rise;
  logic [1:0] chan_rise;
  logic [1:0] line_w;
  logic [1:0] busy_w;

  // Register writes; soft trigger bits are one-cycle pulses
  always_comb begin
    mode_d = mode_q;
    exp_d = exp_q;
    pw_d = pw_q;
    us_d = us_q;
    route_d = route_q;
    soft_d = 2'h0;
    if (reg_write_i) begin
      case (reg_addr_i)
        `REG_MODE: mode_d = reg_wdata_i[7:0];
        // Values above the limit clamp so the range stays 0-25500
        `REG_EXPOSURE: exp_d = (reg_wdata_i[14:0] > `EXPOSURE_MAX || reg_wdata_i[31:15] != 17'h0) ?
                                `EXPOSURE_MAX : reg_wdata_i[14:0];
        `REG_TIMING: begin
          pw_d = reg_wdata_i[0];
          us_d = reg_wdata_i[1];
        end
        `REG_ROUTING: route_d = reg_wdata_i[0];
        `REG_SOFT_TRIG: soft_d = reg_wdata_i[1:0];
        default: ;
      endcase
    end
  end

  // Read data valid in the cycle after the strobe only; unmapped reads zero
  always_comb begin
    rdata_d = 32'h0;
    if (reg_read_i) begin
      case (reg_addr_i)
        `REG_MODE: rdata_d = {24'h0, mode_q};
        `REG_EXPOSURE: rdata_d = {17'h0, exp_q};
        `REG_TIMING: rdata_d = {30'h0, us_q, pw_q};
        `REG_ROUTING: rdata_d = {31'h0, route_q};
        `REG_STATUS: rdata_d = {28'h0, line_q, busy_w};
        default: rdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      mode_q <= `MODE_FREERUN; // Default freerun
      exp_q <= 15'h0;
      pw_q <= 1'b0;
      us_q <= 1'b0;
      route_q <= 1'b0;
      soft_q <= 2'h0;
      rdata_q <= 32'h0;
      line_q <= 2'h0;
    end else begin
      mode_q <= mode_d;
      exp_q <= exp_d;
      pw_q <= pw_d;
      us_q <= us_d;
      route_q <= route_d;
      soft_q <= soft_d;
      rdata_q <= rdata_d;
      line_q <= line_w;
    end
  end

  // Pins pass the synchroniser and edge detector
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_in
      trig_input_sync u_sync (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .pin_i(ext_trig_i[g]),
        .rise_o(rise[g])
      );
    end
  endgenerate

  // Routing: combined uses input 0 for both cameras
  assign chan_rise[0] = rise[0];
  assign chan_rise[1] = route_q ? rise[1] : rise[0];

  generate
    for (g = 0; g < 2; g++) begin : gen_ch
      trig_channel u_chan (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .trigger_mode_setting_i(mode_q),
        .pulse_width_i(pw_q),
        .shutter_timing_microsec_i(us_q),
        .exposure_i(exp_q),
        .soft_trig_i(soft_q[g]),
        .ext_rise_i(chan_rise[g]),
        .exposure_line_o(line_w[g]),
        .busy_o(busy_w[g])
      );
    end
  endgenerate

  assign reg_rdata_o = rdata_q;
  assign exposure_line_o = line_q;
endmodule
`default_nettype wire

// ### trig_control_properties.sv
// Port checker for the trigger and exposure control block
`timescale 1ns/10ps
`default_nettype none
`include "trig_regs.svh"
module trig_control_properties (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  input wire logic [31:0] reg_rdata_o,
  // Pins and camera lines
  input wire logic [1:0] ext_trig_i,
  input wire logic [1:0] exposure_line_o
);
  logic [7:0] mode_q, mode_d;
  logic [1:0] time_q, time_d;
  logic route_q, route_d;
  logic [14:0] exp_q, exp_d;
  logic [31:0] hi_q, hi_d;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  // Shadow of the settings, clamped as the device does, plus the high time of line 0
  always_comb begin
    mode_d = mode_q;
    time_d = time_q;
    route_d = route_q;
    exp_d = exp_q;
    hi_d = exposure_line_o[0] ? hi_q + 32'h1 : 32'h0;
    if (reg_write_i && reg_addr_i == `REG_MODE) mode_d = reg_wdata_i[7:0];
    if (reg_write_i && reg_addr_i == `REG_TIMING) time_d = reg_wdata_i[1:0];
    if (reg_write_i && reg_addr_i == `REG_ROUTING) route_d = reg_wdata_i[0];
    if (reg_write_i && reg_addr_i == `REG_EXPOSURE) begin
      exp_d = (reg_wdata_i > 32'h639c) ? `EXPOSURE_MAX : reg_wdata_i[14:0];
    end
  end
  // Registered shadow; clears with the design so a mid-run reset stays consistent
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      mode_q <= 8'h00;
      time_q <= 2'h0;
      route_q <= 1'b0;
      exp_q <= 15'h0;
      hi_q <= 32'h0;
    end else begin
      mode_q <= mode_d;
      time_q <= time_d;
      route_q <= route_d;
      exp_q <= exp_d;
      hi_q <= hi_d;
    end
  end
  chk_rdata_idle_zero: assert property (!$past(reg_read_i) |-> reg_rdata_o == 32'h0)
    else $error("read data not zero outside the answer cycle");
  chk_mode_readback: assert property (reg_read_i && reg_addr_i == `REG_MODE
    |=> reg_rdata_o == {24'h0, mode_q})
    else $error("mode readback wrong");
  chk_exposure_clamp: assert property (reg_read_i && reg_addr_i == `REG_EXPOSURE
    |=> reg_rdata_o == {17'h0, exp_q})
    else $error("exposure readback not clamped");
  chk_freerun_quiet: assert property (mode_q == `MODE_FREERUN [*3] |-> exposure_line_o == 2'b00)
    else $error("trigger driven in freerun");
  chk_board_pulse_len: assert property ($fell(exposure_line_o[0]) && mode_q != 8'h00 && !time_q[0]
    |-> hi_q == `TRIG_PULSE_CYCLES)
    else $error("trigger pulse length wrong");
  chk_exposure_len: assert property ($fell(exposure_line_o[0]) && mode_q == `MODE_BOARD && time_q == 2'b11
    |-> hi_q == exp_q * `US_CYCLES)
    else $error("exposure pulse length wrong");
  chk_routing_both: assert property (mode_q == `MODE_PASS && !route_q
    |-> exposure_line_o[0] == exposure_line_o[1])
    else $error("combined routing lines differ");
  chk_pass_latency: assert property ($rose(ext_trig_i[0]) && mode_q == `MODE_PASS
    && !exposure_line_o[0] |-> ##[3:12] $rose(exposure_line_o[0]))
    else $error("pass-through trigger missing");
endmodule
bind trig_control trig_control_properties trig_control_properties_inst (.core_clk_i, .resetn_i, .reg_addr_i,
  .reg_wdata_i, .reg_write_i, .reg_read_i, .reg_rdata_o, .ext_trig_i, .exposure_line_o);
`default_nettype wire

// ### cam_model.sv
// Camera model: counts trigger pulses and times the last one on each line
`timescale 1ns/10ps
`default_nettype none
module cam_model (
  // Clock
  input wire logic core_clk_i,
  // Trigger lines
  input wire logic [1:0] line_i,
  // Measurements
  output var int pulses_o [2],
  output var int width_o [2]
);
  int run [2] = '{0, 0};
  initial pulses_o = '{0, 0};
  // A frame is taken per pulse; the high time sets the exposure
  always @(posedge core_clk_i) begin
    for (int k = 0; k < 2; k++) begin
      if (line_i[k]) run[k]++;
      else if (run[k] != 0) begin
        width_o[k] = run[k];
        pulses_o[k]++;
        run[k] = 0;
      end
    end
  end
endmodule
`default_nettype wire

// ### trig_control_bench.sv
// Self-checking bench for the trigger and exposure control block
`timescale 1ns/10ps
`default_nettype none
`include "trig_regs.svh"
module trig_control_bench;
  logic core_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_write_i = 1'b0;
  logic reg_read_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic [1:0] ext_trig_i = 2'h0;
  logic [1:0] exposure_line_o;
  int pulses [2];
  int width [2];
  int error_cnt = 0;
  int num_checks = 0;
  int e0 = 0;
  int e1 = 0;
  // 200 MHz core clock
  always #2.5 core_clk_i = ~core_clk_i;
  trig_control trig_control_inst (.core_clk_i, .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_write_i,
    .reg_read_i, .reg_rdata_o, .ext_trig_i, .exposure_line_o);
  cam_model cam_model_inst (.core_clk_i, .line_i(exposure_line_o), .pulses_o(pulses), .width_o(width));
  task automatic end_sim();
    if (error_cnt == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Strobes drop one edge later so no signal is set twice in a time step
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_write_i <= 1'b1;
    @(posedge core_clk_i);
    reg_write_i <= 1'b0;
    @(posedge core_clk_i);
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [31:0] e);
    reg_addr_i <= a;
    reg_read_i <= 1'b1;
    @(posedge core_clk_i);
    reg_read_i <= 1'b0;
    @(posedge core_clk_i);
    check(reg_rdata_o, e);
  endtask
  // Pin held 10 us, then quiet long enough for any pulse to end
  task automatic ext_pulse(input logic [1:0] m);
    ext_trig_i <= m;
    repeat (2000) @(posedge core_clk_i);
    ext_trig_i <= 2'h0;
    repeat (300) @(posedge core_clk_i);
  endtask
  task automatic expect_trig(input logic [1:0] m, input int w);
    e0 += m[0];
    e1 += m[1];
    check(pulses[0], e0);
    check(pulses[1], e1);
    if (m != 2'h0) check(width[m[0] ? 0 : 1], w);
  endtask
  // Watchdog against a hung run
  initial begin
    #200us;
    error_cnt++;
    end_sim();
  end
  initial begin
    repeat (12) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    @(posedge core_clk_i);
    check(exposure_line_o, 32'h0);
    rd_reg(`REG_MODE, 32'h0);
    wr_reg(`REG_SOFT_TRIG, 32'h3);
    ext_pulse(2'h3);
    expect_trig(2'h0, 0);
    wr_reg(`REG_MODE, 32'h10);
    rd_reg(`REG_MODE, 32'h10);
    for (int c = 1; c < 3; c++) begin
      wr_reg(`REG_SOFT_TRIG, c);
      repeat (300) @(posedge core_clk_i);
      expect_trig(c[1:0], 200);
    end
    wr_reg(`REG_EXPOSURE, 32'hffff);
    rd_reg(`REG_EXPOSURE, 32'h639c);
    wr_reg(`REG_EXPOSURE, 32'h2);
    wr_reg(`REG_TIMING, 32'h3);
    rd_reg(`REG_TIMING, 32'h3);
    wr_reg(`REG_SOFT_TRIG, 32'h1);
    repeat (600) @(posedge core_clk_i);
    expect_trig(2'h1, 400);
    // Zero exposure is legal but must give no pulse at all
    wr_reg(`REG_EXPOSURE, 32'h0);
    wr_reg(`REG_SOFT_TRIG, 32'h1);
    repeat (300) @(posedge core_clk_i);
    expect_trig(2'h0, 0);
    wr_reg(`REG_EXPOSURE, 32'h2);
    wr_reg(`REG_TIMING, 32'h1);
    wr_reg(`REG_SOFT_TRIG, 32'h1);
    repeat (1000) @(posedge core_clk_i);
    check(exposure_line_o, 32'h1);
    rd_reg(`REG_STATUS, 32'h5);
    wr_reg(`REG_MODE, 32'h0);
    repeat (4) @(posedge core_clk_i);
    check(exposure_line_o, 32'h0);
    e0++;
    wr_reg(`REG_TIMING, 32'h0);
    wr_reg(`REG_MODE, 32'ha0);
    ext_pulse(2'h1);
    expect_trig(2'h3, 200);
    ext_pulse(2'h2);
    expect_trig(2'h0, 0);
    wr_reg(`REG_ROUTING, 32'h1);
    rd_reg(`REG_ROUTING, 32'h1);
    ext_pulse(2'h2);
    expect_trig(2'h2, 200);
    ext_pulse(2'h1);
    expect_trig(2'h1, 200);
    rd_reg(4'hf, 32'h0);
    end_sim();
  end
endmodule
`default_nettype wire
